// ---- design/udt_defs.svh ----
// udt_defs.svh: register offsets, field positions, control reset value, channel count and wrap vector code of the up/down compare timer
// assumes: included by the package and the design modules; definitions only
// Overview of operation
// - in up mode, wrap flag sets only when the counter wraps from period compare to zero
// - clear bit or reset forces counter to zero; counting resumes from zero
// - counter clock selectable: inverted external, sub-main, auxiliary, external timer clock
// - first increment after clear on first source rising edge; later ones follow divider
// - compare-mode channel raises its flag when counter equals its compare register
// - full word write to timer control register clears the interrupt vector register
`ifndef UDT_DEFS_SVH
`define UDT_DEFS_SVH
`define UDT_OFS_CTL 12'h000
`define UDT_OFS_CNT 12'h004
`define UDT_OFS_CC0 12'h010
`define UDT_OFS_CC1 12'h014
`define UDT_OFS_CC2 12'h018
`define UDT_OFS_CCM 12'h020
`define UDT_OFS_IV 12'h024
`define UDT_OFS_STAT 12'h028
`define UDT_OFS_MASK 12'h02c
`define UDT_CTL_CLR 2
`define UDT_CTL_MC_LO 4
`define UDT_CTL_ID_LO 6
`define UDT_CTL_SSEL_LO 8
`define UDT_CTL_RST 16'h0000
`define UDT_NCH 3
`define UDT_ST_WRAP 3
`define UDT_IV_WRAP 4'ha
`endif

// ---- design/udt_pkg.sv ----
// udt_pkg.sv: types of the up/down compare timer
// assumes: udt_defs.svh on the include path
`include "udt_defs.svh"
package udt_pkg;
  typedef enum logic [1:0] {UDT_SRC_EXT, UDT_SRC_AUX, UDT_SRC_SUB, UDT_SRC_INV} udt_src_e;
  typedef enum logic [1:0] {UDT_MODE_STOP, UDT_MODE_UP, UDT_MODE_CONT, UDT_MODE_UPDN} udt_mode_e;
  typedef enum logic [1:0] {UDT_ST_IDLE, UDT_ST_DATA} udt_bus_e;
  typedef struct packed {
    logic [15:0] ctl;
    logic [2:0][15:0] ccr;
    logic [2:0] cap;
    logic [3:0] stat;
    logic [3:0] mask;
    udt_bus_e bus;
    logic [11:0] addr;
    logic wr;
    logic [31:0] rdata;
    logic clr_pend;
  } udt_reg_s;
  typedef struct packed {
    logic [15:0] count;
    logic dir_down;
    logic [2:0] pre;
    logic first;
    logic src_d;
  } udt_cnt_s;
endpackage

// ---- design/udt_core.sv ----
// udt_core.sv: counter core with source select, input divider, modes and compare/wrap events
// assumes: clock sources are synchronous levels sampled on clk
`timescale 1ns/1ps
`include "udt_defs.svh"
module udt_core import udt_pkg::*; (
  // clock and control
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // clock sources
  input wire logic ext_clk,
  input wire logic aux_clk,
  input wire logic sub_clk,
  // configuration
  input wire logic clear,
  input wire udt_src_e src_sel,
  input wire logic [1:0] input_divider_sel,
  input wire udt_mode_e mode,
  input wire logic [2:0][15:0] ccr,
  input wire logic [2:0] cap,
  // results
  output logic [15:0] counter_value,
  output logic wrap_evt,
  output logic [2:0] cmp_evt
);
  udt_cnt_s s_r, s_nxt;
  logic src, tick, edge_seen;
  // source mux; inverted external uses the external pin inverted
  always_comb begin
    case (src_sel)
      UDT_SRC_EXT: src = ext_clk;
      UDT_SRC_AUX: src = aux_clk;
      UDT_SRC_SUB: src = sub_clk;
      UDT_SRC_INV: src = ~ext_clk;
      default: src = ext_clk;
    endcase
  end
  // next state: divider prescaler, then count
  always_comb begin
    s_nxt = s_r;
    wrap_evt = 1'b0;
    cmp_evt = 3'b000;
    s_nxt.src_d = src;
    edge_seen = src & ~s_r.src_d;
    tick = 1'b0;
    if (edge_seen && mode != UDT_MODE_STOP) begin
      s_nxt.pre = s_r.pre + 3'd1;
      // first tick after clear ignores the divider, as the silicon does
      if (s_r.first || s_r.pre == ((3'd1 << input_divider_sel) - 3'd1)) begin
        tick = 1'b1;
        s_nxt.pre = 3'd0;
        s_nxt.first = 1'b0;
      end
    end
    if (tick) begin
      case (mode)
        UDT_MODE_UP: begin
          if (s_r.count >= ccr[0]) begin
            s_nxt.count = 16'h0000;
            wrap_evt = (s_r.count == ccr[0]);
          end else begin
            s_nxt.count = s_r.count + 16'h0001;
          end
        end
        UDT_MODE_CONT: begin
          s_nxt.count = s_r.count + 16'h0001;
          wrap_evt = (s_r.count == 16'hffff);
        end
        UDT_MODE_UPDN: begin
          if (s_r.dir_down) begin
            s_nxt.count = s_r.count - 16'h0001;
            if (s_r.count == 16'h0001) begin
              s_nxt.dir_down = 1'b0;
              wrap_evt = 1'b1;
            end
          end else if (s_r.count >= ccr[0]) begin
            s_nxt.dir_down = 1'b1;
            s_nxt.count = s_r.count - 16'h0001;
          end else begin
            s_nxt.count = s_r.count + 16'h0001;
          end
        end
        default: s_nxt.count = s_r.count;
      endcase
      for (int i = 0; i < `UDT_NCH; i++) begin
        cmp_evt[i] = ~cap[i] && (s_nxt.count == ccr[i]);
      end
    end
    if (clear) begin
      s_nxt.count = 16'h0000;
      s_nxt.pre = 3'd0;
      s_nxt.dir_down = 1'b0;
      s_nxt.first = 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      s_r <= '{count: 16'h0000, dir_down: 1'b0, pre: 3'd0, first: 1'b1, src_d: 1'b0};
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end
  assign counter_value = s_r.count;
endmodule

// ---- design/udt_top.sv ----
// udt_top.sv: up/down compare timer with AHB-Lite register slave and masked interrupt
// assumes: single AHB-Lite master, word transfers, clock sources synchronous to clk
//
// The implementer's own choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "udt_defs.svh"
module udt_top import udt_pkg::*; (
  // clock and control
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // clock sources
  input wire logic ext_clk,
  input wire logic aux_clk,
  input wire logic sub_clk,
  // interrupt
  output logic irq
);
  udt_reg_s r_r, r_nxt;
  logic [15:0] counter_value;
  logic wrap_evt;
  logic [2:0] cmp_evt;
  logic [3:0] ev;
  logic [3:0] ivec;

  udt_core u_core (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .ext_clk(ext_clk),
    .aux_clk(aux_clk),
    .sub_clk(sub_clk),
    .clear(r_r.clr_pend),
    .src_sel(udt_src_e'(r_r.ctl[`UDT_CTL_SSEL_LO +: 2])),
    .input_divider_sel(r_r.ctl[`UDT_CTL_ID_LO +: 2]),
    .mode(udt_mode_e'(r_r.ctl[`UDT_CTL_MC_LO +: 2])),
    .ccr(r_r.ccr),
    .cap(r_r.cap),
    .counter_value(counter_value),
    .wrap_evt(wrap_evt),
    .cmp_evt(cmp_evt)
  );

  // highest-priority pending unmasked event; channel 0 ranks first, wrap last
  function automatic logic [3:0] udt_vec(input logic [3:0] p);
    if (p[0]) return 4'h2;
    if (p[1]) return 4'h4;
    if (p[2]) return 4'h6;
    if (p[`UDT_ST_WRAP]) return `UDT_IV_WRAP;
    return 4'h0;
  endfunction

  assign ev = {wrap_evt, cmp_evt};
  assign ivec = udt_vec(r_r.stat & r_r.mask);
  assign hreadyout = 1'b1; // zero wait states
  assign hresp = 1'b0;
  assign hrdata = r_r.rdata;
  assign irq = |(r_r.stat & r_r.mask);

  // bus phases, register writes and sticky flags
  always_comb begin
    r_nxt = r_r;
    r_nxt.clr_pend = 1'b0;
    if (r_r.bus == UDT_ST_DATA && r_r.wr) begin
      case (r_r.addr)
        `UDT_OFS_CTL: begin
          r_nxt.ctl = hwdata[15:0];
          r_nxt.ctl[`UDT_CTL_CLR] = 1'b0; // clear bit is self-clearing
          r_nxt.clr_pend = hwdata[`UDT_CTL_CLR];
          // full word write is the initialising move, so it drops pending vector sources
          r_nxt.stat = 4'h0;
        end
        `UDT_OFS_CC0: r_nxt.ccr[0] = hwdata[15:0];
        `UDT_OFS_CC1: r_nxt.ccr[1] = hwdata[15:0];
        `UDT_OFS_CC2: r_nxt.ccr[2] = hwdata[15:0];
        `UDT_OFS_CCM: r_nxt.cap = hwdata[2:0]; // capture mode lets software bump a compare safely
        `UDT_OFS_STAT: r_nxt.stat = r_r.stat & ~hwdata[3:0];
        `UDT_OFS_MASK: r_nxt.mask = hwdata[3:0];
        default: r_nxt.mask = r_r.mask;
      endcase
    end
    // reading the vector acknowledges the event it reported; taken from the captured read data so that
    // an event arriving between the two bus phases is not dropped unseen
    if (r_r.bus == UDT_ST_DATA && !r_r.wr && r_r.addr == `UDT_OFS_IV) begin
      case (r_r.rdata[3:0])
        4'h2: r_nxt.stat[0] = 1'b0;
        4'h4: r_nxt.stat[1] = 1'b0;
        4'h6: r_nxt.stat[2] = 1'b0;
        `UDT_IV_WRAP: r_nxt.stat[`UDT_ST_WRAP] = 1'b0;
        default: r_nxt.stat = r_nxt.stat;
      endcase
    end
    // set wins over every clear
    r_nxt.stat = r_nxt.stat | ev;
    r_nxt.bus = UDT_ST_IDLE;
    if (hsel && hready && htrans[1]) begin
      r_nxt.bus = UDT_ST_DATA;
      r_nxt.addr = haddr;
      r_nxt.wr = hwrite;
      r_nxt.rdata = 32'h0000_0000;
      if (!hwrite) begin
        case (haddr)
          `UDT_OFS_CTL: r_nxt.rdata = {16'h0000, r_r.ctl};
          `UDT_OFS_CNT: r_nxt.rdata = {16'h0000, counter_value};
          `UDT_OFS_CC0: r_nxt.rdata = {16'h0000, r_r.ccr[0]};
          `UDT_OFS_CC1: r_nxt.rdata = {16'h0000, r_r.ccr[1]};
          `UDT_OFS_CC2: r_nxt.rdata = {16'h0000, r_r.ccr[2]};
          `UDT_OFS_CCM: r_nxt.rdata = {29'h0, r_r.cap};
          `UDT_OFS_IV: r_nxt.rdata = {28'h0, ivec};
          `UDT_OFS_STAT: r_nxt.rdata = {28'h0, r_r.stat};
          `UDT_OFS_MASK: r_nxt.rdata = {28'h0, r_r.mask};
          default: r_nxt.rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      r_r <= '{ctl: `UDT_CTL_RST, ccr: '0, cap: 3'b000, stat: 4'h0, mask: 4'h0, bus: UDT_ST_IDLE,
               addr: 12'h000, wr: 1'b0, rdata: 32'h0000_0000, clr_pend: 1'b0};
    end else if (ce) begin
      r_r <= r_nxt;
    end
  end
endmodule

// ---- verif/udt_top_props.sv ----
// udt_top_props.sv: port-level checks of the compare timer
// assumes: bound to udt_top, one clock domain, hreadyout fed back as hready
`timescale 1ns/1ps
`include "udt_defs.svh"
module udt_top_props (
  // clock and control
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // bus and interrupt
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // accepted address phase, ce included since a frozen slave takes nothing
  wire logic acc = hsel && hready && htrans[1] && ce;
  property p_ready; hreadyout; endproperty
  a_ready: assert property (p_ready) else $error("hreadyout dropped");
  property p_okay; !hresp; endproperty
  a_okay: assert property (p_okay) else $error("error response seen");
  property p_rst; disable iff (!ce) srst |=> hrdata == 32'h0 && !irq; endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  property p_quiet; disable iff (!ce) srst ##1 !srst |-> !irq [*2]; endproperty
  a_quiet: assert property (p_quiet) else $error("irq right after reset");
  property p_hold; !acc |=> $stable(hrdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved without a transfer");
  property p_freeze; !ce |=> $stable(irq) && $stable(hrdata); endproperty
  a_freeze: assert property (p_freeze) else $error("state moved with ce low");
  property p_unmap; acc && !hwrite && haddr >= 12'h030 |=> hrdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  // a stop-mode control write wipes every pending flag, so irq is low unless an event sets a flag in the write's data phase
  property p_ctl; acc && hwrite && haddr == `UDT_OFS_CTL ##1 hwdata[5:4] == 2'b00 && ce |=> !irq; endproperty
  a_ctl: assert property (p_ctl) else $error("irq survived control write");
endmodule
bind udt_top udt_top_props u_props (.clk(clk), .srst(srst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .irq(irq));

// ---- verif/testbench.sv ----
// testbench.sv: self-checking bench of the compare timer over its bus
// assumes: clock sources are slow levels made here, hready looped from hreadyout
`timescale 1ns/1ps
`include "udt_defs.svh"
module testbench;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic lvl = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'b00;
  logic [1:0] sv = 2'd0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rd_v;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic irq;
  int errors = 0;
  int cmp_count = 0;
  // rows: source, divider, edges, expected count
  logic [15:0] rows [5] = '{16'h0505, 16'h5503, 16'ha502, 16'hf902, 16'hb101};
  logic [3:0] st_exp [4] = '{4'h0, 4'h2, 4'h3, 4'hb};
  // only the selected source toggles; the inverted one idles high so a switch makes no edge
  wire logic ext_clk = (sv == 2'd3) ? ~lvl : (sv == 2'd0) & lvl;
  wire logic aux_clk = (sv == 2'd1) & lvl;
  wire logic sub_clk = (sv == 2'd2) & lvl;
  udt_top DUT (.clk(clk), .srst(srst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .ext_clk(ext_clk), .aux_clk(aux_clk), .sub_clk(sub_clk), .irq(irq));
  // 40 mhz clock
  initial begin
    forever #12.5 clk = ~clk;
  end
  task automatic end_of_test();
    if (errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one single word transfer; read data taken at the edge ending the data phase
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge clk); while (hreadyout !== 1'b1 && ++n < 50);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1 && ++n < 50);
    rd_v = hrdata;
    if (n >= 50) errors++;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rd_v, e);
  endtask
  // slow source edges; the idle cycle first keeps a rise off the edge where a pending clear lands,
  // which would swallow it
  task automatic pulse(input int k);
    repeat (k) begin
      @(posedge clk);
      lvl <= 1'b1;
      repeat (3) @(posedge clk);
      lvl <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask
  function automatic logic [31:0] ctl(input logic [1:0] s, input logic [1:0] id, input logic [1:0] m, input logic c);
    return {22'h0, s, id, m, 1'b0, c, 2'b00};
  endfunction
  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rd(`UDT_OFS_CTL, {16'h0, `UDT_CTL_RST});
    rd(`UDT_OFS_CNT, 32'h0);
    wr(`UDT_OFS_CC0, 32'hffff);
    wr(`UDT_OFS_CC2, 32'hffff);
    for (int i = 0; i < 5; i++) begin
      sv <= rows[i][15:14];
      @(posedge clk);
      wr(`UDT_OFS_CTL, ctl(rows[i][15:14], rows[i][13:12], 2'd1, 1'b1));
      pulse(rows[i][11:8]);
      rd(`UDT_OFS_CNT, {24'h0, rows[i][7:0]});
    end
    // up mode to 3 with channel 1 at 2, only the wrap flag unmasked
    wr(`UDT_OFS_CC0, 32'h3);
    wr(`UDT_OFS_CC1, 32'h2);
    wr(`UDT_OFS_MASK, 32'h8);
    wr(`UDT_OFS_CTL, ctl(2'd2, 2'd0, 2'd1, 1'b1));
    for (int k = 0; k < 4; k++) begin
      pulse(1);
      rd(`UDT_OFS_STAT, {28'h0, st_exp[k]});
      chk({31'h0, irq}, {31'h0, k == 3});
    end
    wr(`UDT_OFS_STAT, 32'h8);
    rd(`UDT_OFS_STAT, 32'h3);
    chk({31'h0, irq}, 32'h0);
    // stop at the period value, then clear and restart: no stray wrap flag
    pulse(3);
    // unmask all so both compare flags stand behind the vector; reading it acks channel 0 only
    wr(`UDT_OFS_MASK, 32'hf);
    rd(`UDT_OFS_IV, 32'h2);
    wr(`UDT_OFS_CTL, ctl(2'd2, 2'd0, 2'd0, 1'b0));
    rd(`UDT_OFS_IV, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(`UDT_OFS_CTL, ctl(2'd2, 2'd0, 2'd1, 1'b1));
    pulse(1);
    rd(`UDT_OFS_CNT, 32'h1);
    rd(`UDT_OFS_STAT, 32'h0);
    // channel 1 bumped by one inside its compare event the safe way, then capture mode raises nothing
    wr(`UDT_OFS_CC0, 32'h5);
    wr(`UDT_OFS_CTL, ctl(2'd2, 2'd0, 2'd1, 1'b1));
    pulse(2);
    rd(`UDT_OFS_STAT, 32'h2);
    wr(`UDT_OFS_CCM, 32'h2);
    wr(`UDT_OFS_CC1, 32'h3);
    wr(`UDT_OFS_CCM, 32'h0);
    wr(`UDT_OFS_STAT, 32'h2);
    pulse(1);
    rd(`UDT_OFS_STAT, 32'h2);
    wr(`UDT_OFS_CCM, 32'h2);
    wr(`UDT_OFS_CC1, 32'h4);
    wr(`UDT_OFS_STAT, 32'h2);
    pulse(1);
    rd(`UDT_OFS_STAT, 32'h0);
    // up/down turns at the period value and flags the wrap on the way back to zero
    wr(`UDT_OFS_CC0, 32'h2);
    wr(`UDT_OFS_MASK, 32'h8);
    wr(`UDT_OFS_CTL, ctl(2'd2, 2'd0, 2'd3, 1'b1));
    pulse(4);
    rd(`UDT_OFS_CNT, 32'h0);
    rd(`UDT_OFS_IV, {28'h0, `UDT_IV_WRAP});
    rd(`UDT_OFS_STAT, 32'h1);
    // continuous mode runs past the period value without a wrap flag
    wr(`UDT_OFS_CTL, ctl(2'd2, 2'd0, 2'd2, 1'b1));
    pulse(3);
    rd(`UDT_OFS_CNT, 32'h3);
    rd(`UDT_OFS_STAT, 32'h1);
    wr(12'h100, 32'hffffffff);
    rd(12'h100, 32'h0);
    ce <= 1'b0;
    @(posedge clk);
    ce <= 1'b1;
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rd(`UDT_OFS_CNT, 32'h0);
    end_of_test();
  end
  // watchdog, far beyond the few hundred cycles the sequence needs
  initial begin
    #1000000;
    errors++;
    end_of_test();
  end
endmodule
